// ---- rtl/real_math_pkg.sv ----
// Constants, opcodes and register map of the real math status unit.
// Assumes one 100 MHz sys_clk and an AXI4-Lite master on the far side.
// Notes on behaviour
// - Double-word increment adds one, decrement subtracts one, result to output.
// - Increment and decrement are signed; most positive exceeds most negative.
// - Increment, decrement, real add and subtract update zero, overflow, negative.
// - Enable-out clears on overflow, run-time error or indirect address error 0006.
// - Real add and subtract give a 32-bit float sum or difference.
// - All real values use single-precision binary floating-point encoding.
// - Overflow also marks illegal values; then zero, negative invalid, operands kept.
// - Add, subtract, square root without overflow give valid result, zero, negative.
// - Real multiply gives the float product, real divide the float quotient.
// - Multiply, divide update zero, overflow, negative, divide-by-zero; illegal sets overflow.
// - Divide-by-zero leaves the other flags unchanged and operands untouched.
// - Multiply, divide give valid result and flags only without overflow or divide-by-zero.
// - Multiply, divide clear enable-out on overflow, divide-by-zero, run-time, address error.
// - Square root of a float input, updating zero, overflow and negative.
// - Natural logarithm writes base-e logarithm of the input as float.
// - Natural exponential writes e to the power of the input as float.
// - Logarithm, exponential clear enable-out only on overflow or address error 0006.
// - Logarithm, exponential update zero, overflow, negative and may raise run-time flag.
package real_math_pkg;

	// Bus shape
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// Register byte addresses
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_OPA    = 8'h04;
	localparam logic [7:0] ADDR_OPB    = 8'h08;
	localparam logic [7:0] ADDR_RESULT = 8'h0C;
	localparam logic [7:0] ADDR_STATUS = 8'h10;
	localparam logic [7:0] ADDR_ERR    = 8'h14;

	// Control and status fields
	localparam int CTRL_OP_W      = 4;
	localparam int FAULT_ADDR_BIT = 8;
	localparam int FAULT_RUN_BIT  = 9;
	localparam int STAT_W         = 7;

	// Answers and codes
	localparam logic [1:0]  RESP_OKAY    = 2'h0;
	localparam logic [1:0]  RESP_SLVERR  = 2'h2;
	localparam logic [15:0] ERR_INDIRECT = 16'h0006;
	localparam logic [15:0] ERR_NONE     = 16'h0000;

	// Number constants
	localparam logic [31:0] INT_MAX  = 32'h7FFF_FFFF;
	localparam logic [31:0] INT_MIN  = 32'h8000_0000;
	localparam logic [31:0] DW_ONE   = 32'h0000_0001;
	localparam logic [31:0] FP_LN2   = 32'h3F31_7218;
	localparam logic [31:0] FP_LOG2E = 32'h3FB8_AA3B;
	localparam logic [7:0]  EXP_BIAS = 8'h7F;
	localparam logic [7:0]  EXP_ALL  = 8'hFF;
	localparam logic [7:0]  FIX_LIM  = 8'h87;
	localparam logic [7:0]  ALIGN_MAX = 8'h1B;
	localparam logic [23:0] FRAC_ONE = 24'h80_0000;
	localparam logic [15:0] CORR_K   = 16'h58C1;
	localparam int FRAC_W     = 23;
	localparam int ITER_STEPS = 26;

	typedef enum logic [3:0] {
		INCR_DWORD_OP = 4'h0,
		DECR_DWORD_OP = 4'h1,
		ADD_REAL_OP   = 4'h2,
		SUB_REAL_OP   = 4'h3,
		MUL_REAL_OP   = 4'h4,
		DIV_REAL_OP   = 4'h5,
		SQRT_REAL_OP  = 4'h6,
		LN_REAL_OP    = 4'h7,
		EXP_REAL_OP   = 4'h8
	} op_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_RUN  = 2'h1,
		ST_WAIT = 2'h3
	} state_t;

endpackage

// ---- rtl/iter_root_quot.sv ----
// Iterative mantissa divider and square root, one bit per clock.
// Assumes the caller holds its operands until done and starts only when idle.
module iter_root_quot (
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        srst,
	// Request
	input  wire logic        start,
	input  wire logic        sqrtMode,
	input  wire logic [51:0] opWide,
	input  wire logic [23:0] opNarrow,
	// Answer
	output logic             done,
	output logic [25:0]      res
);
	import real_math_pkg::*;

	logic [51:0] rad_q;
	logic [23:0] den_q;
	logic [27:0] rem_q;
	logic [4:0]  cnt_q;
	logic        mode_q;
	logic        run_q;
	logic [27:0] r2;
	logic [27:0] trial;
	logic [27:0] remNext;
	logic        take;

	// One restoring step: sqrt brings two radicand bits, divide compares directly
	always_comb begin
		r2 = mode_q ? {rem_q[25:0], rad_q[51:50]} : rem_q;
		trial = mode_q ? {res, 2'b01} : {4'h0, den_q};
		take = (r2 >= trial);
		remNext = take ? r2 - trial : r2;
	end

	// Iteration register set
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			rad_q <= '0;
			den_q <= '0;
			rem_q <= '0;
			cnt_q <= '0;
			mode_q <= 1'b0;
			run_q <= 1'b0;
			done <= 1'b0;
			res <= '0;
		end else begin
			done <= 1'b0;
			if (start) begin
				rad_q <= opWide;
				den_q <= opNarrow;
				rem_q <= sqrtMode ? '0 : opWide[27:0];
				res <= '0;
				cnt_q <= 5'(ITER_STEPS - 1);
				mode_q <= sqrtMode;
				run_q <= 1'b1;
			end else if (run_q) begin
				rem_q <= mode_q ? remNext : remNext << 1;
				rad_q <= rad_q << 2;
				res <= {res[24:0], take};
				cnt_q <= cnt_q - 5'h01;
				if (cnt_q == 5'h00) begin
					run_q <= 1'b0;
					done <= 1'b1;
				end
			end
		end
	end

endmodule

// ---- rtl/real_math_status_unit.sv ----
// Real and double-word math unit with registered status flags.
// Assumes an AXI4-Lite master; software issues one operation at a time.
module real_math_status_unit (
	// Clock and reset
	input  wire logic                             sys_clk,
	input  wire logic                             srst,
	// AXI4-Lite write address and data
	input  wire logic [real_math_pkg::ADDR_W-1:0] awaddr,
	input  wire logic                             awvalid,
	output logic                                  awready,
	input  wire logic [real_math_pkg::DATA_W-1:0] wdata,
	input  wire logic [3:0]                       wstrb,
	input  wire logic                             wvalid,
	output logic                                  wready,
	// AXI4-Lite write response
	output logic [1:0]                            bresp,
	output logic                                  bvalid,
	input  wire logic                             bready,
	// AXI4-Lite read
	input  wire logic [real_math_pkg::ADDR_W-1:0] araddr,
	input  wire logic                             arvalid,
	output logic                                  arready,
	output logic [real_math_pkg::DATA_W-1:0]      rdata,
	output logic [1:0]                            rresp,
	output logic                                  rvalid,
	input  wire logic                             rready,
	// Status
	output logic                                  enableOut,
	output logic                                  zeroFlag,
	output logic                                  ovfFlag,
	output logic                                  negFlag,
	output logic                                  dzFlag,
	output logic                                  runFlag,
	output logic                                  busy
);
	import real_math_pkg::*;

	// ----------------------------------------
	// Float helpers
	// ----------------------------------------

	// Overflow above the top exponent, flush to zero below the bottom
	function automatic logic [32:0] fpPack(input logic s, input logic signed [10:0] e, input logic [23:0] m);
		if (e >= $signed({3'b000, EXP_ALL}))
			fpPack = {1'b1, 32'h0000_0000};
		else if (e <= 11'sh000)
			fpPack = '0;
		else
			fpPack = {1'b0, s, e[7:0], m[22:0]};
	endfunction

	function automatic logic [32:0] fpAdd(input logic [31:0] a, input logic [31:0] b);
		logic [31:0] x;
		logic [31:0] y;
		logic [7:0] d;
		logic [27:0] mx;
		logic [27:0] my;
		logic [27:0] s;
		logic signed [10:0] e;
		if (a[30:0] < b[30:0]) begin
			x = b;
			y = a;
		end else begin
			x = a;
			y = b;
		end
		mx = (x[30:23] == 8'h00) ? '0 : {2'b01, x[22:0], 3'b000};
		my = (y[30:23] == 8'h00) ? '0 : {2'b01, y[22:0], 3'b000};
		d = x[30:23] - y[30:23];
		my = (d > ALIGN_MAX) ? '0 : my >> d;
		s = (x[31] ^ y[31]) ? mx - my : mx + my;
		e = $signed({3'b000, x[30:23]}) + 11'sh001;
		for (int i = 0; i < ALIGN_MAX; i++)
			if (!s[27] && s != '0) begin
				s = s << 1;
				e = e - 11'sh001;
			end
		fpAdd = (s == '0) ? '0 : fpPack(x[31], e, s[27:4]);
	endfunction

	function automatic logic [32:0] fpMul(input logic [31:0] a, input logic [31:0] b);
		logic [47:0] p;
		logic signed [10:0] e;
		p = {1'b1, a[22:0]} * {1'b1, b[22:0]};
		e = $signed({3'b000, a[30:23]}) + $signed({3'b000, b[30:23]}) - $signed({3'b000, EXP_BIAS});
		if (a[30:23] == 8'h00 || b[30:23] == 8'h00)
			fpMul = '0;
		else if (p[47])
			fpMul = fpPack(a[31] ^ b[31], e + 11'sh001, p[47:24]);
		else
			fpMul = fpPack(a[31] ^ b[31], e, p[46:23]);
	endfunction

	// Second-order fix of log2(1+f) against f; shared by ln and exp
	function automatic logic [23:0] approxCorr(input logic [22:0] f);
		logic [46:0] g;
		logic [39:0] c;
		g = f * (FRAC_ONE - {1'b0, f});
		c = g[46:23] * CORR_K;
		approxCorr = c[39:16];
	endfunction

	// Signed fixed point with 23 fraction bits to float
	function automatic logic [31:0] fixToFp(input logic signed [31:0] v);
		logic [31:0] m;
		logic signed [10:0] e;
		logic [32:0] r;
		m = v[31] ? 32'(-v) : 32'(v);
		e = $signed({3'b000, FIX_LIM});
		for (int i = 0; i < DATA_W - 1; i++)
			if (!m[31] && m != '0) begin
				m = m << 1;
				e = e - 11'sh001;
			end
		r = fpPack(v[31], e, m[31:8]);
		fixToFp = (m == '0) ? '0 : r[31:0];
	endfunction

	// ln(x) = ln2 * (exponent + log2 of mantissa)
	function automatic logic [32:0] fpLn(input logic [31:0] a);
		logic signed [31:0] fx;
		logic [32:0] r;
		fx = ($signed({24'h00_0000, a[30:23]}) - $signed({24'h00_0000, EXP_BIAS})) <<< FRAC_W;
		fx = fx + $signed({9'h000, a[22:0]}) + $signed({8'h00, approxCorr(a[22:0])});
		r = fpMul(fixToFp(fx), FP_LN2);
		fpLn = {1'b0, r[31:0]};
	endfunction

	// e^x = 2^(x*log2e): integer part to exponent, fraction to mantissa
	function automatic logic [32:0] fpExp(input logic [31:0] a);
		logic [32:0] t;
		logic [31:0] mag;
		logic signed [31:0] fx;
		logic signed [31:0] n;
		logic [23:0] corr;
		t = fpMul(a, FP_LOG2E);
		if (t[32] || t[30:23] >= FIX_LIM) begin
			fpExp = a[31] ? '0 : {1'b1, 32'h0000_0000};
		end else begin
			mag = (t[30:23] == 8'h00) ? '0 : {8'h00, 1'b1, t[22:0]};
			if (t[30:23] >= EXP_BIAS)
				mag = mag << (t[30:23] - EXP_BIAS);
			else
				mag = mag >> (EXP_BIAS - t[30:23]);
			fx = t[31] ? -$signed(mag) : $signed(mag);
			n = fx >>> FRAC_W;
			corr = approxCorr(fx[22:0]);
			fpExp = fpPack(1'b0, $signed(n[10:0]) + $signed({3'b000, EXP_BIAS}), {1'b1, fx[22:0] - corr[22:0]});
		end
	endfunction

	function automatic logic [31:0] strbMerge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] s);
		for (int i = 0; i < DATA_W / 8; i++)
			strbMerge[8*i +: 8] = s[i] ? nw[8*i +: 8] : old[8*i +: 8];
	endfunction

	// ----------------------------------------
	// State
	// ----------------------------------------

	state_t      state_q;
	state_t      state_d;
	op_t         op_q;
	logic        faultAddr_q;
	logic        faultRun_q;
	logic [31:0] opA_q;
	logic [31:0] opB_q;
	logic [31:0] result_q;
	logic [15:0] errCode_q;
	logic        awHeld_q;
	logic        wHeld_q;
	logic [7:0]  awAddr_q;
	logic [31:0] wData_q;
	logic [3:0]  wStrb_q;
	logic        awHeld_d;
	logic        wHeld_d;
	logic        bvalid_d;
	logic        rvalid_d;
	logic        wrDone;
	logic        wrBad;
	logic        arFire;
	logic        startOp;
	logic        lnExp;
	logic        blocked;
	logic        iterNeed;
	logic        iterStart;
	logic        finishNow;
	logic [31:0] outWord;
	logic        outOvf;
	logic        outDz;
	logic        outRun;
	logic        resZero;
	logic        illA;
	logic        illB;
	logic [32:0] fpR;
	logic [51:0] engWide;
	logic        engDone;
	logic [25:0] engRes;

	// ----------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------

	// Address and data may arrive in either order; both held before commit
	always_comb begin
		wrDone = awHeld_q && wHeld_q && !bvalid;
		awHeld_d = (awHeld_q || (awvalid && awready)) && !wrDone;
		wHeld_d = (wHeld_q || (wvalid && wready)) && !wrDone;
		bvalid_d = (bvalid && !bready) || wrDone;
		arFire = arvalid && arready;
		rvalid_d = (rvalid && !rready) || arFire;
		wrBad = !(awAddr_q == ADDR_CTRL || awAddr_q == ADDR_OPA || awAddr_q == ADDR_OPB) || state_q != ST_IDLE;
		startOp = wrDone && !wrBad && awAddr_q == ADDR_CTRL && wStrb_q[0];
	end

	// Handshake flops
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			awHeld_q <= 1'b0;
			wHeld_q <= 1'b0;
			awready <= 1'b0;
			wready <= 1'b0;
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
			awAddr_q <= '0;
			wData_q <= '0;
			wStrb_q <= '0;
		end else begin
			awHeld_q <= awHeld_d;
			wHeld_q <= wHeld_d;
			awready <= !awHeld_d && !bvalid_d;
			wready <= !wHeld_d && !bvalid_d;
			bvalid <= bvalid_d;
			if (awvalid && awready)
				awAddr_q <= awaddr;
			if (wvalid && wready) begin
				wData_q <= wdata;
				wStrb_q <= wstrb;
			end
			if (wrDone)
				bresp <= wrBad ? RESP_SLVERR : RESP_OKAY;
		end
	end

	// Software-written registers; refused while an operation runs
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			opA_q <= '0;
			opB_q <= '0;
			op_q <= INCR_DWORD_OP;
			faultAddr_q <= 1'b0;
			faultRun_q <= 1'b0;
		end else if (wrDone && !wrBad) begin
			if (awAddr_q == ADDR_OPA)
				opA_q <= strbMerge(opA_q, wData_q, wStrb_q);
			if (awAddr_q == ADDR_OPB)
				opB_q <= strbMerge(opB_q, wData_q, wStrb_q);
			if (startOp) begin
				op_q <= op_t'(wData_q[CTRL_OP_W-1:0]);
				faultAddr_q <= wStrb_q[1] && wData_q[FAULT_ADDR_BIT];
				faultRun_q <= wStrb_q[1] && wData_q[FAULT_RUN_BIT];
			end
		end
	end

	// Read channel
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= '0;
			rresp <= RESP_OKAY;
		end else begin
			arready <= !rvalid_d;
			rvalid <= rvalid_d;
			if (arFire) begin
				rresp <= RESP_OKAY;
				unique case (araddr)
					ADDR_CTRL: rdata <= {22'h00_0000, faultRun_q, faultAddr_q, 4'h0, op_q};
					ADDR_OPA: rdata <= opA_q;
					ADDR_OPB: rdata <= opB_q;
					ADDR_RESULT: rdata <= result_q;
					ADDR_STATUS: rdata <= {25'h000_0000, busy, enableOut, runFlag, dzFlag, negFlag, ovfFlag, zeroFlag};
					ADDR_ERR: rdata <= {16'h0000, errCode_q};
					default: begin
						rdata <= '0;
						rresp <= RESP_SLVERR;
					end
				endcase
			end
		end
	end

	// ----------------------------------------
	// Operation evaluation
	// ----------------------------------------

	assign illA = (opA_q[30:23] == EXP_ALL);
	assign illB = (opB_q[30:23] == EXP_ALL);
	assign lnExp = (op_q == LN_REAL_OP) || (op_q == EXP_REAL_OP);
	// Address fault always stops; a run-time fault stops all but ln and exp
	assign blocked = faultAddr_q || (faultRun_q && !lnExp);
	assign engWide = (op_q == SQRT_REAL_OP) ? ({3'b000, 1'b1, opA_q[22:0], 25'h000_0000} << !opA_q[23])
		: {28'h000_0000, 1'b1, opA_q[22:0]};

	// Result and outcome of the issued operation
	always_comb begin
		outWord = '0;
		outOvf = 1'b0;
		outDz = 1'b0;
		outRun = 1'b0;
		iterNeed = 1'b0;
		fpR = '0;
		unique case (op_q)
			INCR_DWORD_OP: begin
				outWord = opA_q + DW_ONE;
				outOvf = (opA_q == INT_MAX);
			end
			DECR_DWORD_OP: begin
				outWord = opA_q - DW_ONE;
				outOvf = (opA_q == INT_MIN);
			end
			ADD_REAL_OP, SUB_REAL_OP: begin
				fpR = fpAdd(opA_q, {opB_q[31] ^ (op_q == SUB_REAL_OP), opB_q[30:0]});
				outWord = fpR[31:0];
				outOvf = fpR[32] || illA || illB;
			end
			MUL_REAL_OP: begin
				fpR = fpMul(opA_q, opB_q);
				outWord = fpR[31:0];
				outOvf = fpR[32] || illA || illB;
			end
			DIV_REAL_OP: begin
				fpR = engRes[25] ? fpPack(opA_q[31] ^ opB_q[31],
					$signed({3'b000, opA_q[30:23]}) - $signed({3'b000, opB_q[30:23]})
					+ $signed({3'b000, EXP_BIAS}), engRes[25:2])
					: fpPack(opA_q[31] ^ opB_q[31],
					$signed({3'b000, opA_q[30:23]}) - $signed({3'b000, opB_q[30:23]})
					+ $signed({3'b000, EXP_BIAS}) - 11'sh001, engRes[24:1]);
				outDz = !illA && !illB && opB_q[30:23] == 8'h00;
				iterNeed = !illA && !illB && !outDz && opA_q[30:23] != 8'h00;
				// Engine answer is stale unless this divide really iterated
				outOvf = illA || illB || (iterNeed && fpR[32]);
				outWord = iterNeed ? fpR[31:0] : '0;
			end
			SQRT_REAL_OP: begin
				fpR = fpPack(1'b0, $signed(({3'b000, opA_q[30:23]} + {3'b000, EXP_BIAS}) >> 1), engRes[24:1]);
				outOvf = illA || (opA_q[31] && opA_q[30:23] != 8'h00);
				iterNeed = !outOvf && opA_q[30:23] != 8'h00;
				outWord = iterNeed ? fpR[31:0] : '0;
			end
			LN_REAL_OP: begin
				fpR = fpLn(opA_q);
				outOvf = illA || opA_q[31] || opA_q[30:23] == 8'h00;
				outRun = outOvf;
				outWord = fpR[31:0];
			end
			EXP_REAL_OP: begin
				fpR = fpExp(opA_q);
				outOvf = fpR[32] || illA;
				outRun = outOvf;
				outWord = fpR[31:0];
			end
			default: outOvf = 1'b1;
		endcase
		resZero = (op_q == INCR_DWORD_OP || op_q == DECR_DWORD_OP) ? outWord == '0 : outWord[30:0] == '0;
	end

	assign iterStart = (state_q == ST_RUN) && iterNeed && !blocked;
	assign finishNow = ((state_q == ST_RUN) && !iterStart) || ((state_q == ST_WAIT) && engDone);

	// Divide and square root take one mantissa bit per clock
	iter_root_quot engine (
		.sys_clk  (sys_clk),
		.srst     (srst),
		.start    (iterStart),
		.sqrtMode (op_q == SQRT_REAL_OP),
		.opWide   (engWide),
		.opNarrow ({1'b1, opB_q[22:0]}),
		.done     (engDone),
		.res      (engRes)
	);

	// Sequencer: one evaluation per issued instruction
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ST_IDLE: if (startOp) state_d = ST_RUN;
			ST_RUN: state_d = iterStart ? ST_WAIT : ST_IDLE;
			ST_WAIT: if (engDone) state_d = ST_IDLE;
			default: state_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			state_q <= ST_IDLE;
			busy <= 1'b0;
		end else begin
			state_q <= state_d;
			busy <= (state_d != ST_IDLE);
		end
	end

	// ----------------------------------------
	// Flags and result
	// ----------------------------------------

	// Flags hold until the next finishing operation touches them
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			result_q <= '0;
			errCode_q <= ERR_NONE;
			enableOut <= 1'b1;
			zeroFlag <= 1'b0;
			ovfFlag <= 1'b0;
			negFlag <= 1'b0;
			dzFlag <= 1'b0;
			runFlag <= 1'b0;
		end else if (finishNow) begin
			errCode_q <= faultAddr_q ? ERR_INDIRECT : ERR_NONE;
			if (faultAddr_q) begin
				enableOut <= 1'b0;
			end else if (faultRun_q && !lnExp) begin
				enableOut <= 1'b0;
				runFlag <= 1'b1;
			end else if (outDz) begin
				dzFlag <= 1'b1;
				enableOut <= 1'b0;
			end else if (outOvf) begin
				ovfFlag <= 1'b1;
				zeroFlag <= 1'b0;
				negFlag <= 1'b0;
				enableOut <= 1'b0;
				runFlag <= outRun || faultRun_q;
				if (op_q == MUL_REAL_OP || op_q == DIV_REAL_OP)
					dzFlag <= 1'b0;
			end else begin
				result_q <= outWord;
				zeroFlag <= resZero;
				negFlag <= outWord[31] && !resZero;
				ovfFlag <= 1'b0;
				enableOut <= 1'b1;
				runFlag <= lnExp && faultRun_q;
				if (op_q == MUL_REAL_OP || op_q == DIV_REAL_OP)
					dzFlag <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------

	localparam int ITER_LO = 26;
	localparam int ITER_HI = 28;

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (srst);

	sequence sIterIssue;
		iterStart;
	endsequence

	sequence sIterRetire;
		##[ITER_LO:ITER_HI] (state_q == ST_WAIT && engDone);
	endsequence

	chk_incr_value: assert property (finishNow && !blocked && op_q == INCR_DWORD_OP && opA_q != INT_MAX
		|=> result_q == $past(opA_q) + DW_ONE && !ovfFlag) else $error("increment result wrong");
	chk_signed_wrap: assert property (finishNow && !blocked && op_q == DECR_DWORD_OP && opA_q == INT_MIN
		|=> ovfFlag && !enableOut) else $error("signed decrement wrap missed");
	chk_clean_flags: assert property (finishNow && !blocked && !outOvf && !outDz
		|=> enableOut && !ovfFlag && (zeroFlag == (result_q[30:0] == '0 && (result_q[31] == 1'b0
		|| $past(op_q) > DECR_DWORD_OP)))) else $error("flags after clean result wrong");
	chk_ovf_keeps: assert property (finishNow && !blocked && outOvf && !outDz
		|=> $stable(result_q) && !zeroFlag && !negFlag && ovfFlag) else $error("overflow altered result");
	chk_dz_hold: assert property (finishNow && !blocked && outDz
		|=> dzFlag && !enableOut && $stable(ovfFlag) && $stable(zeroFlag) && $stable(result_q))
		else $error("divide by zero touched flags");
	chk_addr_fault: assert property (finishNow && faultAddr_q
		|=> !enableOut && errCode_q == ERR_INDIRECT && $stable(result_q)) else $error("address fault missed");
	chk_lnexp_run: assert property (finishNow && lnExp && faultRun_q && !faultAddr_q && !outOvf
		|=> enableOut && runFlag) else $error("run fault cleared enable on ln or exp");
	chk_iter_bound: assert property (sIterIssue |-> sIterRetire) else $error("iteration did not retire in time");
	chk_one_finish: assert property (finishNow |=> !finishNow) else $error("two finishes for one issue");

endmodule

// ---- test/real_math_status_unit_tb.sv ----
// Bench for the real math status unit: AXI4-Lite tasks and operation sequences.
// Assumes the design package; bready and rready stay high once a transfer starts.
module real_math_status_unit_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import real_math_pkg::*;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic        sys_clk = 1'b0, srst = 1'b1;
	logic [7:0]  awaddr = '0, araddr = '0;
	logic [31:0] wdata = '0, rdata;
	logic [3:0]  wstrb = 4'hF;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp;
	logic        enableOut, zeroFlag, ovfFlag, negFlag, dzFlag, runFlag, busy;
	int          n_fail = 0, checks_done = 0;
	// Free-running 100 MHz clock
	always #5 sys_clk = ~sys_clk;
	real_math_status_unit dut (.sys_clk, .srst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
		.wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
		.enableOut, .zeroFlag, .ovfFlag, .negFlag, .dzFlag, .runFlag, .busy);
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	// Verdict and end of run
	task automatic results();
		$display("checks %0d, mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// A spent bound means a hung handshake
	task automatic tmo(input int n, input int lim);
		if (n >= lim) begin
			n_fail++;
			$display("unexpected at %0t: bus timeout", $time);
			results();
		end
	endtask
	// Address and data offered together, each dropped when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		for (n = 0; n < 200; n++) begin
			@(posedge sys_clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		r = bresp;
		tmo(n, 200);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		for (n = 0; n < 200; n++) begin
			@(posedge sys_clk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		d = rdata;
		r = rresp;
		tmo(n, 200);
	endtask
	// Log and exp are approximate, so within one percent
	function automatic logic near(input logic [31:0] g, e);
		real d;
		d = $bitstoshortreal(g) - $bitstoshortreal(e);
		return (d < 0.01 * $bitstoshortreal(e)) && (-d < 0.01 * $bitstoshortreal(e));
	endfunction
	// Load operands, issue, poll busy, then check status and result
	task automatic op(input logic [31:0] a, b, input logic [9:0] c, input logic [6:0] st, input logic [31:0] e,
			input bit tol = 0);
		logic [31:0] s;
		logic [1:0]  r;
		int          n;
		wr(ADDR_OPA, a, r);
		wr(ADDR_OPB, b, r);
		wr(ADDR_CTRL, {22'h0, c}, r);
		chk({30'h0, r}, {30'h0, RESP_OKAY});
		for (n = 0; n < 100; n++) begin
			rd(ADDR_STATUS, s, r);
			if (s[6] === 1'b0) break;
		end
		tmo(n, 100);
		chk(s, {25'h0, st});
		chk({25'h0, busy, enableOut, runFlag, dzFlag, negFlag, ovfFlag, zeroFlag}, {25'h0, st});
		rd(ADDR_RESULT, s, r);
		if (tol) chk({31'h0, near(s, e)}, 32'h1);
		else chk(s, e);
	endtask
	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		logic [31:0] rs;
		logic [1:0]  r;
		repeat (10) @(posedge sys_clk);
		srst <= 1'b0;
		@(posedge sys_clk);
		rd(ADDR_STATUS, rs, r);
		chk(rs, 32'h0000_0020);
		op(32'h0000_0005, 0, INCR_DWORD_OP, 7'h20, 32'h0000_0006);
		op(INT_MAX, 0, INCR_DWORD_OP, 7'h02, 32'h0000_0006);
		op(INT_MIN, 0, DECR_DWORD_OP, 7'h02, 32'h0000_0006);
		op(32'h0000_0000, 0, DECR_DWORD_OP, 7'h24, 32'hFFFF_FFFF);
		op(32'h0000_0001, 0, DECR_DWORD_OP, 7'h21, 32'h0000_0000);
		$display("test integer done");
		op(32'h3F80_0000, 32'h4000_0000, ADD_REAL_OP, 7'h20, 32'h4040_0000);
		op(32'h3F80_0000, 32'h4000_0000, SUB_REAL_OP, 7'h24, 32'hBF80_0000);
		op(32'h4040_0000, 0, DIV_REAL_OP, 7'h0C, 32'hBF80_0000);
		op(32'h4000_0000, 32'h4040_0000, MUL_REAL_OP, 7'h20, 32'h40C0_0000);
		op(32'h7F80_0000, 32'h3F80_0000, MUL_REAL_OP, 7'h02, 32'h40C0_0000);
		op(32'h40C0_0000, 32'h4000_0000, DIV_REAL_OP, 7'h20, 32'h4040_0000);
		$display("test real done");
		op(32'h4080_0000, 0, SQRT_REAL_OP, 7'h20, 32'h4000_0000);
		op(32'hBF80_0000, 0, SQRT_REAL_OP, 7'h02, 32'h4000_0000);
		op(32'h4000_0000, 0, LN_REAL_OP, 7'h20, 32'h3F31_7218, 1);
		op(32'h3F80_0000, 0, EXP_REAL_OP, 7'h20, 32'h402D_F854, 1);
		op(32'h4000_0000, 0, 10'h207, 7'h30, 32'h3F31_7218, 1);
		$display("test numeric done");
		op(32'h0000_0005, 0, 10'h100, 7'h10, 32'h3F31_7218, 1);
		rd(ADDR_ERR, rs, r);
		chk(rs, {16'h0, ERR_INDIRECT});
		op(32'hBF80_0000, 0, LN_REAL_OP, 7'h12, 32'h3F31_7218, 1);
		op(32'h3F80_0000, 0, EXP_REAL_OP, 7'h20, 32'h402D_F854, 1);
		op(32'h0000_0005, 0, 10'h200, 7'h10, 32'h402D_F854, 1);
		$display("test faults done");
		op(32'h40C0_0000, 32'h4000_0000, 10'h009, 7'h02, 32'h402D_F854, 1);
		wr(ADDR_CTRL, {28'h0, DIV_REAL_OP}, r);
		wr(ADDR_OPA, 32'h0000_0000, r);
		chk({30'h0, r}, {30'h0, RESP_SLVERR});
		rd(ADDR_OPA, rs, r);
		chk(rs, 32'h40C0_0000);
		repeat (30) @(posedge sys_clk);
		op(32'h4040_0000, 0, DIV_REAL_OP, 7'h08, 32'h4040_0000);
		wr(ADDR_RESULT, 32'h0000_0001, r);
		chk({30'h0, r}, {30'h0, RESP_SLVERR});
		rd(8'h3C, rs, r);
		chk({30'h0, r}, {30'h0, RESP_SLVERR});
		chk(rs, 32'h0000_0000);
		$display("test bus done");
		results();
	end
endmodule
